// ==== mgmt_host_model.sv ====
`include "pwm_cfg_params.svh"
`default_nettype none
module mgmt_host_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_page,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_page = 8'hFF;
    cmd_code = 8'hFF;
    cmd_wdata = 16'hFFFF;
  end

  // One command: drive after an edge, hold to the taking edge, then take
  // the answer and scramble the idle fields so stale values never match.
  task automatic xfer(input logic wr, input logic [7:0] page,
                      input logic [7:0] code, input logic [15:0] wdata,
                      output logic seen, output logic err,
                      output logic [15:0] rdata);
    logic [15:0] wd;
    wd = wdata;
    if (wr && code == `CMD_SWITCHING_FREQUENCY) begin
      if (wd < 16'h00C8) wd = 16'h00C8;
      if (wd > 16'h07D0) wd = 16'h07D0;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_page = page;
    cmd_code = code;
    cmd_wdata = wd;
    @(posedge clk);
    #1;
    seen = rsp_valid;
    err = rsp_err;
    rdata = rsp_rdata;
    cmd_valid = 1'b0;
    cmd_write = ~wr;
    cmd_page = ~page;
    cmd_code = ~code;
    cmd_wdata = ~wd;
  endtask : xfer

  // A write and a read of the same register in back-to-back cycles; the
  // request stays up across both taking edges.
  task automatic wr_rd(input logic [7:0] page, input logic [7:0] code,
                       input logic [15:0] wdata, output logic err,
                       output logic [15:0] rdata);
    logic [15:0] wd;
    wd = wdata;
    if (code == `CMD_SWITCHING_FREQUENCY) begin
      if (wd < 16'h00C8) wd = 16'h00C8;
      if (wd > 16'h07D0) wd = 16'h07D0;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_page = page;
    cmd_code = code;
    cmd_wdata = wd;
    @(posedge clk);
    #1;
    cmd_write = 1'b0;
    cmd_wdata = ~wd;
    @(posedge clk);
    #1;
    err = rsp_err;
    rdata = rsp_rdata;
    cmd_valid = 1'b0;
    cmd_write = 1'b1;
    cmd_page = ~page;
    cmd_code = ~code;
  endtask : wr_rd
endmodule : mgmt_host_model
`default_nettype wire

// ==== page_cfg_regs.sv ====
`include "pwm_cfg_params.svh"
`default_nettype none
module page_cfg_regs
  import pwm_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_freq,
  input wire logic wr_mode,
  input wire logic wr_on,
  input wire logic wr_off,
  input wire logic [15:0] wdata,
  output logic [15:0] switching_frequency,
  output logic [7:0] conversion_mode,
  output logic [15:0] input_turn_on_threshold,
  output logic [15:0] input_turn_off_threshold
);

  page_regs_t s_q;
  page_regs_t s_d;
  logic mode_ok;

  assign mode_ok = (wdata[7:0] == `MODE_MAX_EFFICIENCY) ||
                   (wdata[7:0] == `MODE_MAX_POWER) ||
                   (wdata[7:0] == `MODE_MAKER_DEFINED);

  always_comb begin
    s_d = s_q;
    if (srst) begin
      s_d.switching_frequency = `RST_SWITCHING_FREQUENCY;
      s_d.conversion_mode = `RST_CONVERSION_MODE;
      s_d.input_turn_on_threshold = `RST_INPUT_TURN_ON_THRESHOLD;
      s_d.input_turn_off_threshold = `RST_INPUT_TURN_OFF_THRESHOLD;
    end else begin
      if (wr_freq) begin
        s_d.switching_frequency = wdata;
      end
      if (wr_mode && mode_ok) begin
        s_d.conversion_mode = wdata[7:0];
      end
      if (wr_on) begin
        s_d.input_turn_on_threshold = wdata;
      end
      if (wr_off) begin
        s_d.input_turn_off_threshold = wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign switching_frequency = s_q.switching_frequency;
  assign conversion_mode = s_q.conversion_mode;
  assign input_turn_on_threshold = s_q.input_turn_on_threshold;
  assign input_turn_off_threshold = s_q.input_turn_off_threshold;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_reset_values;
    @(posedge clk) srst |=>
      s_q.switching_frequency == 16'h0258 &&
      s_q.conversion_mode == 8'h03 &&
      s_q.input_turn_on_threshold == 16'h02BC &&
      s_q.input_turn_off_threshold == 16'h01F4;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("Page registers did not take their reset values.");

  property p_bad_mode_kept;
    @(posedge clk) disable iff (srst)
      wr_mode && !mode_ok |=> $stable(s_q.conversion_mode);
  endproperty
  a_bad_mode_kept: assert property (p_bad_mode_kept)
    else $error("Unsupported mode code changed the stored mode.");

endmodule : page_cfg_regs
`default_nettype wire

// ==== pwm_cfg_params.svh ====
`ifndef PWM_CFG_PARAMS_SVH
`define PWM_CFG_PARAMS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define CMD_SWITCHING_FREQUENCY 8'h33
`define CMD_CONVERSION_MODE 8'h34
`define CMD_INPUT_TURN_ON_THRESHOLD 8'h35
`define CMD_INPUT_TURN_OFF_THRESHOLD 8'h36

// ----------------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------------
`define RST_SWITCHING_FREQUENCY 16'h0258
`define RST_CONVERSION_MODE 8'h03
`define RST_INPUT_TURN_ON_THRESHOLD 16'h02BC
`define RST_INPUT_TURN_OFF_THRESHOLD 16'h01F4
`define MODE_MAX_EFFICIENCY 8'h00
`define MODE_MAX_POWER 8'h03
`define MODE_MAKER_DEFINED 8'h04

// ----------------------------------------------------------------------
// Loop configuration word bit positions
// ----------------------------------------------------------------------
`define LOOP_AUTO_PHASE_BIT 0
`define LOOP_DIODE_EFF_BIT 6
`define LOOP_DIODE_POWER_BIT 28
`define LOOP_CONFIG_WIDTH 32

`endif

// ==== pwm_cfg_pkg.sv ====
`default_nettype none
package pwm_cfg_pkg;

  // Stored configuration of one output page.
  typedef struct packed {
    logic [15:0] switching_frequency;
    logic [7:0] conversion_mode;
    logic [15:0] input_turn_on_threshold;
    logic [15:0] input_turn_off_threshold;
  } page_regs_t;

  // Derived behaviour of one output page.
  typedef struct packed {
    logic vin_ok;
    logic vdown_decay;
    logic phase_drop_en;
    logic diode_emu_en;
  } page_ctl_t;

endpackage : pwm_cfg_pkg
`default_nettype wire

// ==== pwm_freq_mode_vin_threshold_regs.sv ====
`include "pwm_cfg_params.svh"
`default_nettype none
module pwm_freq_mode_vin_threshold_regs
  import pwm_cfg_pkg::*;
#(
  parameter int NUM_PAGES = 2
) (
  input wire logic clk,
  input wire logic srst,
  // Command port from the management bus engine.
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_page,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_rdata,
  // Per-page inputs from the loop and the input voltage monitor.
  input wire logic [NUM_PAGES*`LOOP_CONFIG_WIDTH-1:0] loop_config_word,
  input wire logic [NUM_PAGES*16-1:0] vin_code,
  // Per-page behaviour outputs.
  output logic [NUM_PAGES*16-1:0] switching_frequency_khz,
  output logic [NUM_PAGES-1:0] output_enable_permit,
  output logic [NUM_PAGES-1:0] vdown_immediate_decay,
  output logic [NUM_PAGES-1:0] phase_drop_enable,
  output logic [NUM_PAGES-1:0] diode_emulation_enable
);

  typedef struct packed {
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_rdata;
    page_ctl_t [NUM_PAGES-1:0] ctl;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  logic page_hit;
  logic code_hit;
  logic [NUM_PAGES-1:0] page_sel;
  logic [NUM_PAGES-1:0] wr_freq;
  logic [NUM_PAGES-1:0] wr_mode;
  logic [NUM_PAGES-1:0] wr_on;
  logic [NUM_PAGES-1:0] wr_off;
  logic [15:0] freq_w [NUM_PAGES];
  logic [7:0] mode_w [NUM_PAGES];
  logic signed [15:0] on_w [NUM_PAGES];
  logic signed [15:0] off_w [NUM_PAGES];
  logic signed [15:0] vin_w [NUM_PAGES];
  logic [`LOOP_CONFIG_WIDTH-1:0] loop_w [NUM_PAGES];

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  assign page_hit = (cmd_page < 8'(NUM_PAGES));

  always_comb begin
    case (cmd_code)
      `CMD_SWITCHING_FREQUENCY: code_hit = 1'b1;
      `CMD_CONVERSION_MODE: code_hit = 1'b1;
      `CMD_INPUT_TURN_ON_THRESHOLD: code_hit = 1'b1;
      `CMD_INPUT_TURN_OFF_THRESHOLD: code_hit = 1'b1;
      default: code_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Page register sets
  // ----------------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PAGES; gp++) begin : g_page
      logic wr_any;
      assign page_sel[gp] = page_hit && (cmd_page == 8'(gp));
      assign wr_any = cmd_valid && cmd_write && page_sel[gp];
      assign wr_freq[gp] = wr_any &&
                           (cmd_code == `CMD_SWITCHING_FREQUENCY);
      assign wr_mode[gp] = wr_any && (cmd_code == `CMD_CONVERSION_MODE);
      assign wr_on[gp] = wr_any &&
                         (cmd_code == `CMD_INPUT_TURN_ON_THRESHOLD);
      assign wr_off[gp] = wr_any &&
                          (cmd_code == `CMD_INPUT_TURN_OFF_THRESHOLD);
      assign vin_w[gp] = vin_code[gp*16 +: 16];
      assign loop_w[gp] = loop_config_word[gp*`LOOP_CONFIG_WIDTH +:
                                           `LOOP_CONFIG_WIDTH];

      page_cfg_regs i_page_cfg_regs (
        .clk(clk),
        .srst(srst),
        .wr_freq(wr_freq[gp]),
        .wr_mode(wr_mode[gp]),
        .wr_on(wr_on[gp]),
        .wr_off(wr_off[gp]),
        .wdata(cmd_wdata),
        .switching_frequency(freq_w[gp]),
        .conversion_mode(mode_w[gp]),
        .input_turn_on_threshold(on_w[gp]),
        .input_turn_off_threshold(off_w[gp])
      );

      assign switching_frequency_khz[gp*16 +: 16] = freq_w[gp];
      assign output_enable_permit[gp] = s_q.ctl[gp].vin_ok;
      assign vdown_immediate_decay[gp] = s_q.ctl[gp].vdown_decay;
      assign phase_drop_enable[gp] = s_q.ctl[gp].phase_drop_en;
      assign diode_emulation_enable[gp] = s_q.ctl[gp].diode_emu_en;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] rd;
    logic eff;
    logic mfr;
    logic pwr;
    rd = 16'h0000;
    eff = 1'b0;
    mfr = 1'b0;
    pwr = 1'b0;
    s_d = s_q;
    s_d.rsp_valid = cmd_valid;
    s_d.rsp_err = cmd_valid && !(page_hit && code_hit);
    for (int p = 0; p < NUM_PAGES; p++) begin
      if (page_sel[p]) begin
        case (cmd_code)
          `CMD_SWITCHING_FREQUENCY: rd = freq_w[p];
          `CMD_CONVERSION_MODE: rd = {8'h00, mode_w[p]};
          `CMD_INPUT_TURN_ON_THRESHOLD: rd = on_w[p];
          `CMD_INPUT_TURN_OFF_THRESHOLD: rd = off_w[p];
          default: rd = 16'h0000;
        endcase
      end
    end
    if (cmd_valid && !cmd_write) begin
      s_d.rsp_rdata = rd;
    end
    for (int p = 0; p < NUM_PAGES; p++) begin
      eff = (mode_w[p] == `MODE_MAX_EFFICIENCY);
      mfr = (mode_w[p] == `MODE_MAKER_DEFINED);
      pwr = (mode_w[p] == `MODE_MAX_POWER);
      // Voltage drops decay at once unless the turn-off profile applies.
      s_d.ctl[p].vdown_decay = eff || mfr;
      if (pwr) begin
        s_d.ctl[p].phase_drop_en =
          loop_w[p][`LOOP_AUTO_PHASE_BIT];
        s_d.ctl[p].diode_emu_en =
          loop_w[p][`LOOP_DIODE_POWER_BIT];
      end else begin
        s_d.ctl[p].phase_drop_en = 1'b1;
        s_d.ctl[p].diode_emu_en = loop_w[p][`LOOP_DIODE_EFF_BIT] ||
          (mfr && loop_w[p][`LOOP_DIODE_POWER_BIT]);
      end
      // Hysteresis: enable above the rising level, drop below falling.
      if (s_q.ctl[p].vin_ok) begin
        s_d.ctl[p].vin_ok = !(vin_w[p] < off_w[p]);
      end else begin
        s_d.ctl[p].vin_ok = (vin_w[p] > on_w[p]);
      end
    end
    if (srst) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rsp_valid = s_q.rsp_valid;
  assign rsp_err = s_q.rsp_err;
  assign rsp_rdata = s_q.rsp_rdata;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  property p_rsp_next;
    cmd_valid |=> rsp_valid ##1 (!rsp_valid || $past(cmd_valid));
  endproperty
  a_rsp_next: assert property (p_rsp_next)
    else $error("Command answer not given one cycle later.");

  property p_freq_readback;
    cmd_valid && cmd_write && page_hit &&
    cmd_code == `CMD_SWITCHING_FREQUENCY ##1
    cmd_valid && !cmd_write && cmd_page == $past(cmd_page) &&
    cmd_code == `CMD_SWITCHING_FREQUENCY
    |=> rsp_rdata == $past(cmd_wdata, 2) && !rsp_err;
  endproperty
  a_freq_readback: assert property (p_freq_readback)
    else $error("Switching frequency did not read back as written.");

  property p_bad_code_err;
    cmd_valid && !code_hit |=> rsp_err;
  endproperty
  a_bad_code_err: assert property (p_bad_code_err)
    else $error("Unknown command code answered without error.");

  property p_bad_page_err;
    cmd_valid && !page_hit |=> rsp_err;
  endproperty
  a_bad_page_err: assert property (p_bad_page_err)
    else $error("Command to a missing page answered without error.");

  property p_good_cmd_ok;
    cmd_valid && page_hit && code_hit |=> !rsp_err;
  endproperty
  a_good_cmd_ok: assert property (p_good_cmd_ok)
    else $error("Valid command answered with an error.");

  property p_rsp_idle;
    !cmd_valid |=> !rsp_valid;
  endproperty
  a_rsp_idle: assert property (p_rsp_idle)
    else $error("Answer strobe raised without a command.");

  property p_rdata_hold;
    !(cmd_valid && !cmd_write) |=> $stable(rsp_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data changed without a read.");

  generate
    for (gp = 0; gp < NUM_PAGES; gp++) begin : g_chk
      property p_freq_write;
        wr_freq[gp] |=>
          switching_frequency_khz[gp*16 +: 16] == $past(cmd_wdata);
      endproperty
      a_freq_write: assert property (p_freq_write)
        else $error("Frequency output does not show the written value.");

      property p_mode_write;
        wr_mode[gp] && (cmd_wdata[7:0] == `MODE_MAX_EFFICIENCY ||
        cmd_wdata[7:0] == `MODE_MAX_POWER ||
        cmd_wdata[7:0] == `MODE_MAKER_DEFINED) |=>
          mode_w[gp] == $past(cmd_wdata[7:0]);
      endproperty
      a_mode_write: assert property (p_mode_write)
        else $error("Supported mode code was not stored.");

      property p_on_write;
        wr_on[gp] |=> on_w[gp] == $past(cmd_wdata);
      endproperty
      a_on_write: assert property (p_on_write)
        else $error("Rising input level not stored as written.");

      property p_off_write;
        wr_off[gp] |=> off_w[gp] == $past(cmd_wdata);
      endproperty
      a_off_write: assert property (p_off_write)
        else $error("Falling input level not stored as written.");

      property p_decay;
        !$past(srst) |->
          vdown_immediate_decay[gp] ==
          ($past(mode_w[gp]) != `MODE_MAX_POWER);
      endproperty
      a_decay: assert property (p_decay)
        else $error("Voltage drop style does not follow the mode.");

      property p_toff_profile;
        !$past(srst) && $past(mode_w[gp]) == `MODE_MAX_POWER |->
          !vdown_immediate_decay[gp];
      endproperty
      a_toff_profile: assert property (p_toff_profile)
        else $error("Power mode used immediate decay.");

      property p_drop_forced;
        !$past(srst) && $past(mode_w[gp]) != `MODE_MAX_POWER |->
          phase_drop_enable[gp];
      endproperty
      a_drop_forced: assert property (p_drop_forced)
        else $error("Phase dropping off outside power mode.");

      property p_drop_power;
        !$past(srst) && $past(mode_w[gp]) == `MODE_MAX_POWER |->
          phase_drop_enable[gp] ==
          $past(loop_w[gp][`LOOP_AUTO_PHASE_BIT]);
      endproperty
      a_drop_power: assert property (p_drop_power)
        else $error("Power mode phase drop not from loop bit 0.");

      property p_diode_eff;
        !$past(srst) && $past(mode_w[gp]) == `MODE_MAX_EFFICIENCY |->
          diode_emulation_enable[gp] ==
          $past(loop_w[gp][`LOOP_DIODE_EFF_BIT]);
      endproperty
      a_diode_eff: assert property (p_diode_eff)
        else $error("Efficiency mode diode emulation not from bit 6.");

      property p_diode_power;
        !$past(srst) && $past(mode_w[gp]) == `MODE_MAX_POWER |->
          diode_emulation_enable[gp] ==
          $past(loop_w[gp][`LOOP_DIODE_POWER_BIT]);
      endproperty
      a_diode_power: assert property (p_diode_power)
        else $error("Power mode diode emulation not from bit 28.");

      property p_diode_mfr;
        !$past(srst) && $past(mode_w[gp]) == `MODE_MAKER_DEFINED |->
          diode_emulation_enable[gp] ==
          ($past(loop_w[gp][`LOOP_DIODE_EFF_BIT]) ||
           $past(loop_w[gp][`LOOP_DIODE_POWER_BIT]));
      endproperty
      a_diode_mfr: assert property (p_diode_mfr)
        else $error("Maker mode diode emulation not from bit 6 or 28.");

      property p_vin_rise;
        !$past(srst) && !output_enable_permit[gp] &&
        vin_w[gp] > on_w[gp] |=> output_enable_permit[gp];
      endproperty
      a_vin_rise: assert property (p_vin_rise)
        else $error("Output not permitted after input rose above level.");

      property p_vin_hold_low;
        !output_enable_permit[gp] && !(vin_w[gp] > on_w[gp]) |=>
          !output_enable_permit[gp];
      endproperty
      a_vin_hold_low: assert property (p_vin_hold_low)
        else $error("Output permitted below the rising level.");

      property p_vin_fall;
        output_enable_permit[gp] && vin_w[gp] < off_w[gp] |=>
          !output_enable_permit[gp];
      endproperty
      a_vin_fall: assert property (p_vin_fall)
        else $error("Output kept after input fell below level.");

      c_vin_cycle: cover property (
        !output_enable_permit[gp] ##1 output_enable_permit[gp] ##[1:50]
        !output_enable_permit[gp]);
      c_mode_eff: cover property (
        wr_mode[gp] && cmd_wdata[7:0] == `MODE_MAX_EFFICIENCY ##1
        mode_w[gp] == `MODE_MAX_EFFICIENCY);
      c_mode_bad: cover property (
        wr_mode[gp] && cmd_wdata[7:0] > `MODE_MAKER_DEFINED);
    end
  endgenerate

  c_err_rsp: cover property (rsp_valid && rsp_err);

endmodule : pwm_freq_mode_vin_threshold_regs
`default_nettype wire

// ==== pwm_freq_mode_vin_threshold_regs_tb.sv ====
`include "pwm_cfg_params.svh"
`default_nettype none
module pwm_freq_mode_vin_threshold_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk, srst, cmd_valid, cmd_write, rsp_valid, rsp_err;
  logic [7:0] cmd_page, cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata;
  logic [63:0] loop_word;
  logic [31:0] vin, freq_khz;
  logic [1:0] permit, decay, pdrop, demu;
  int err_count = 0;
  int checked = 0;

  mgmt_host_model i_mgmt_host_model (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata));

  pwm_freq_mode_vin_threshold_regs #(.NUM_PAGES(2))
    i_pwm_freq_mode_vin_threshold_regs (
    .clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_page(cmd_page), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
    .loop_config_word(loop_word), .vin_code(vin),
    .switching_frequency_khz(freq_khz), .output_enable_permit(permit),
    .vdown_immediate_decay(decay), .phase_drop_enable(pdrop),
    .diode_emulation_enable(demu));

  // ----------------------------------------------------------------------
  // Compare and command helpers
  // ----------------------------------------------------------------------
  task automatic chk_word(input string name, input logic [15:0] exp,
                          input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string name, input logic exp,
                         input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  // Read data is only judged for reads that are expected to succeed.
  task automatic cmd(input logic wr, input logic [7:0] page, code,
                     input logic [15:0] wdata, input logic exp_err,
                     input logic [15:0] exp_rdata);
    logic s, e;
    logic [15:0] d;
    i_mgmt_host_model.xfer(wr, page, code, wdata, s, e, d);
    chk_bit("answer strobe", 1'b1, s);
    chk_bit("answer error", exp_err, e);
    if (!wr && !exp_err) chk_word("read data", exp_rdata, d);
  endtask : cmd

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    for (int p = 0; p < 2; p++) begin
      cmd(0, p[7:0], `CMD_SWITCHING_FREQUENCY, 0, 0, 16'h0258);
      cmd(0, p[7:0], `CMD_CONVERSION_MODE, 0, 0, 16'h0003);
      cmd(0, p[7:0], `CMD_INPUT_TURN_ON_THRESHOLD, 0, 0, 16'h02BC);
      cmd(0, p[7:0], `CMD_INPUT_TURN_OFF_THRESHOLD, 0, 0, 16'h01F4);
    end
  endtask : t_reset

  task automatic t_freq;
    logic e;
    logic [15:0] d;
    cmd(1, 1, `CMD_SWITCHING_FREQUENCY, 16'h00C8, 0, 0);
    cmd(1, 0, `CMD_SWITCHING_FREQUENCY, 16'h07D0, 0, 0);
    cmd(0, 1, `CMD_SWITCHING_FREQUENCY, 0, 0, 16'h00C8);
    cmd(0, 0, `CMD_SWITCHING_FREQUENCY, 0, 0, 16'h07D0);
    chk_word("frequency out page 0", 16'h07D0, freq_khz[15:0]);
    chk_word("frequency out page 1", 16'h00C8, freq_khz[31:16]);
    i_mgmt_host_model.wr_rd(0, `CMD_SWITCHING_FREQUENCY, 16'h0320, e, d);
    chk_bit("back to back error", 1'b0, e);
    chk_word("read after write", 16'h0320, d);
    chk_word("frequency out page 0", 16'h0320, freq_khz[15:0]);
  endtask : t_freq

  task automatic t_refuse;
    cmd(1, 2, `CMD_SWITCHING_FREQUENCY, 16'h0300, 1, 0);
    cmd(1, 0, 8'h37, 16'h0300, 1, 0);
    cmd(0, 2, `CMD_CONVERSION_MODE, 0, 1, 0);
    cmd(0, 1, `CMD_SWITCHING_FREQUENCY, 0, 0, 16'h00C8);
  endtask : t_refuse

  task automatic t_modes;
    logic [7:0] m;
    logic [31:0] w;
    logic ed, ep, ee;
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? `MODE_MAX_EFFICIENCY :
          (i == 1) ? `MODE_MAX_POWER : `MODE_MAKER_DEFINED;
      cmd(1, 0, `CMD_CONVERSION_MODE, {8'hA5, m}, 0, 0);
      cmd(0, 0, `CMD_CONVERSION_MODE, 0, 0, {8'h00, m});
      for (int k = 0; k < 8; k++) begin
        w = 32'hEFFF_FFBE;
        w[0] = k[0];
        w[6] = k[1];
        w[28] = k[2];
        loop_word = {~w, w};
        settle();
        ed = (m != `MODE_MAX_POWER);
        ep = ed | w[0];
        ee = (m == `MODE_MAX_EFFICIENCY) ? w[6] :
             (m == `MODE_MAX_POWER) ? w[28] : (w[6] | w[28]);
        chk_bit("decay page 0", ed, decay[0]);
        chk_bit("phase drop page 0", ep, pdrop[0]);
        chk_bit("diode page 0", ee, demu[0]);
        chk_bit("decay page 1", 1'b0, decay[1]);
        chk_bit("phase drop page 1", ~w[0], pdrop[1]);
        chk_bit("diode page 1", ~w[28], demu[1]);
      end
    end
  endtask : t_modes

  task automatic t_bad_mode;
    cmd(1, 0, `CMD_CONVERSION_MODE, 16'h0005, 0, 0);
    cmd(1, 0, `CMD_CONVERSION_MODE, 16'h00FF, 0, 0);
    cmd(0, 0, `CMD_CONVERSION_MODE, 0, 0, 16'h0004);
    settle();
    chk_bit("decay after bad mode", 1'b1, decay[0]);
  endtask : t_bad_mode

  task automatic vstep(input logic [15:0] v0, v1, input logic e0, e1);
    vin = {v1, v0};
    settle();
    chk_bit("permit page 0", e0, permit[0]);
    chk_bit("permit page 1", e1, permit[1]);
  endtask : vstep

  task automatic t_vin;
    cmd(1, 0, `CMD_INPUT_TURN_ON_THRESHOLD, 16'h0100, 0, 0);
    cmd(1, 0, `CMD_INPUT_TURN_OFF_THRESHOLD, 16'hFF00, 0, 0);
    cmd(0, 0, `CMD_INPUT_TURN_OFF_THRESHOLD, 0, 0, 16'hFF00);
    vstep(16'h0100, 16'h02BC, 0, 0);
    vstep(16'h0101, 16'h02BD, 1, 1);
    vstep(16'hFF00, 16'h01F4, 1, 1);
    vstep(16'hFEFF, 16'h01F3, 0, 0);
  endtask : t_vin

  // Reset in mid-run: page 0 permit is up before and must drop after.
  task automatic t_mid_reset;
    vin = 32'h0200_0200;
    settle();
    chk_bit("permit before reset", 1'b1, permit[0]);
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
    chk_bit("permit after reset", 1'b0, permit[0]);
    chk_bit("decay after reset", 1'b0, decay[0]);
  endtask : t_mid_reset

  task end_of_test;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #20000;
    err_count++;
    end_of_test();
  end

  initial begin
    srst = 1'b1;
    loop_word = 64'h0;
    vin = 32'h0;
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_freq();
    t_refuse();
    t_modes();
    t_bad_mode();
    t_vin();
    t_mid_reset();
    end_of_test();
  end
endmodule : pwm_freq_mode_vin_threshold_regs_tb
`default_nettype wire
